// ### logic/comparator_control.sv
// Comparator control: input selection, result sync, event flag, capture routing, APB registers
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Result high when positive exceeds negative
// - Mux on, converter off: channel picks negative
// - Otherwise negative pin drives negative input
// - Bandgap select replaces positive pin input
// - Disable bit powers comparator down anytime
// - Raw output synchronised, one-two cycle latency
// - Selected edge type sets interrupt flag
// - Vector execution clears interrupt flag
// - Writing one clears flag; zero ignored
// - Request when flag, enable, global enable
// - Mode: toggle, reserved, falling, rising
// - Routing bit feeds result to capture
// - Input disable kills pin buffer, reads zero
// - Upper six disable bits read zero
// - Status register resets to zero
module comparator_control (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output var   logic [31:0] prdata,
  output var   logic        pready,
  output var   logic        pslverr,
  input  wire  logic        comparator_raw,
  input  wire  logic        global_irq_enable,
  input  wire  logic        irq_vector_ack,
  input  wire  logic        positive_pin_level,
  input  wire  logic        negative_pin_level,
  output var   logic        positive_pin_read,
  output var   logic        negative_pin_read,
  output var   logic        positive_buffer_off,
  output var   logic        negative_buffer_off,
  output var   comparator_control_pkg::analog_select_t analog_select,
  output var   logic        capture_trigger,
  output var   logic        comparator_irq,
  output var   logic        irq
);

  comparator_control_pkg::control_t ctrl;
  comparator_control_pkg::control_t next_ctrl;
  logic       irq_flag;
  logic       next_irq_flag;
  logic       negative_mux_enable;
  logic       next_negative_mux_enable;
  logic       converter_enable;
  logic       next_converter_enable;
  logic [2:0] channel_select;
  logic [2:0] next_channel_select;
  logic [1:0] pin_disable;
  logic [1:0] next_pin_disable;
  logic [1:0] event_status;
  logic [1:0] next_event_status;
  logic [1:0] event_enable;
  logic [1:0] next_event_enable;
  logic [comparator_control_pkg::sync_stages-1:0] sync;
  logic       result_prev;
  logic       wr;
  logic       rd;
  logic       mapped;
  logic       event_hit;
  logic [31:0] next_prdata;
  comparator_control_pkg::analog_select_t next_analog_select;

  function automatic logic edge_match(input logic [1:0] mode, input logic now, input logic was);
    case (mode)
      comparator_control_pkg::mode_toggle:  edge_match = now ^ was;
      comparator_control_pkg::mode_falling: edge_match = was & ~now;
      comparator_control_pkg::mode_rising:  edge_match = now & ~was;
      default:                              edge_match = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] status_byte(input comparator_control_pkg::control_t c,
                                             input logic res, input logic flag);
    status_byte = {c.comparator_disable, c.bandgap_select, res, flag,
                   c.comparator_irq_enable, c.capture_routing_enable, c.irq_mode};
  endfunction

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  always_comb begin
    case (paddr)
      comparator_control_pkg::control_status_addr,
      comparator_control_pkg::converter_ctrl_addr,
      comparator_control_pkg::pin_disable_addr,
      comparator_control_pkg::mux_select_addr,
      comparator_control_pkg::event_status_addr,
      comparator_control_pkg::event_clear_addr,
      comparator_control_pkg::event_enable_addr: mapped = 1'b1;
      default:                                   mapped = 1'b0;
    endcase
  end

  // Event on the synchronised result; the comparator itself is analog outside
  assign event_hit = edge_match(ctrl.irq_mode, sync[comparator_control_pkg::sync_stages-1],
                                result_prev);

  always_comb begin
    next_ctrl                = ctrl;
    next_irq_flag            = irq_flag;
    next_negative_mux_enable = negative_mux_enable;
    next_converter_enable    = converter_enable;
    next_channel_select      = channel_select;
    next_pin_disable         = pin_disable;
    next_event_status        = event_status;
    next_event_enable        = event_enable;
    if (irq_vector_ack) begin
      next_irq_flag = 1'b0;
    end
    if (wr) begin
      case (paddr)
        comparator_control_pkg::control_status_addr: begin
          next_ctrl.comparator_disable     = pwdata[comparator_control_pkg::disable_bit];
          next_ctrl.bandgap_select         = pwdata[comparator_control_pkg::bandgap_bit];
          next_ctrl.comparator_irq_enable  = pwdata[comparator_control_pkg::irq_enable_bit];
          next_ctrl.capture_routing_enable = pwdata[comparator_control_pkg::capture_bit];
          next_ctrl.irq_mode = {pwdata[comparator_control_pkg::mode_hi_bit],
                                pwdata[comparator_control_pkg::mode_lo_bit]};
          if (pwdata[comparator_control_pkg::irq_flag_bit]) begin
            next_irq_flag = 1'b0;
          end
        end
        comparator_control_pkg::converter_ctrl_addr: begin
          next_negative_mux_enable = pwdata[comparator_control_pkg::mux_enable_bit];
          next_converter_enable    = pwdata[comparator_control_pkg::converter_enable_bit];
        end
        comparator_control_pkg::pin_disable_addr: begin
          next_pin_disable = pwdata[1:0];
        end
        comparator_control_pkg::mux_select_addr: begin
          next_channel_select = pwdata[2:0];
        end
        comparator_control_pkg::event_clear_addr: begin
          next_event_status = event_status & ~pwdata[1:0];
        end
        comparator_control_pkg::event_enable_addr: begin
          next_event_enable = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // Hardware set wins over a simultaneous clear
    if (event_hit) begin
      next_irq_flag        = 1'b1;
      next_event_status[0] = 1'b1;
    end
    if (sync[comparator_control_pkg::sync_stages-1] ^ result_prev) begin
      next_event_status[1] = 1'b1;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        comparator_control_pkg::control_status_addr:
          next_prdata = {24'h00_0000, status_byte(ctrl, sync[comparator_control_pkg::sync_stages-1],
                                                  irq_flag)};
        comparator_control_pkg::converter_ctrl_addr:
          next_prdata = {24'h00_0000, converter_enable, negative_mux_enable, 6'h00};
        comparator_control_pkg::pin_disable_addr:
          next_prdata = {30'h0000_0000, pin_disable};
        comparator_control_pkg::mux_select_addr:
          next_prdata = {29'h0000_0000, channel_select};
        comparator_control_pkg::event_status_addr:
          next_prdata = {30'h0000_0000, event_status};
        comparator_control_pkg::event_enable_addr:
          next_prdata = {30'h0000_0000, event_enable};
        default:
          next_prdata = 32'h0000_0000;
      endcase
    end else begin
      next_prdata = prdata;
    end
  end

  always_comb begin
    next_analog_select.power_down  = ctrl.comparator_disable;
    next_analog_select.use_bandgap = ctrl.bandgap_select;
    next_analog_select.neg_from_channel = negative_mux_enable & ~converter_enable;
    next_analog_select.neg_channel = channel_select;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                <= comparator_control_pkg::control_t'(comparator_control_pkg::control_status_reset[5:0]);
      irq_flag            <= 1'b0;
      negative_mux_enable <= 1'b0;
      converter_enable    <= 1'b0;
      channel_select      <= comparator_control_pkg::mux_select_reset[2:0];
      pin_disable         <= comparator_control_pkg::pin_disable_reset;
      event_status        <= comparator_control_pkg::event_reset;
      event_enable        <= comparator_control_pkg::event_reset;
      sync                <= '0;
      result_prev         <= 1'b0;
      prdata              <= 32'h0000_0000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      analog_select       <= '0;
      capture_trigger     <= 1'b0;
      comparator_irq      <= 1'b0;
      irq                 <= 1'b0;
      positive_pin_read   <= 1'b0;
      negative_pin_read   <= 1'b0;
      positive_buffer_off <= 1'b0;
      negative_buffer_off <= 1'b0;
    end else begin
      ctrl                <= next_ctrl;
      irq_flag            <= next_irq_flag;
      negative_mux_enable <= next_negative_mux_enable;
      converter_enable    <= next_converter_enable;
      channel_select      <= next_channel_select;
      pin_disable         <= next_pin_disable;
      event_status        <= next_event_status;
      event_enable        <= next_event_enable;
      sync <= {sync[comparator_control_pkg::sync_stages-2:0], comparator_raw};
      result_prev         <= sync[comparator_control_pkg::sync_stages-1];
      prdata              <= next_prdata;
      pready              <= psel & ~penable;
      pslverr             <= psel & ~penable & ~mapped;
      analog_select       <= next_analog_select;
      capture_trigger <= ctrl.capture_routing_enable &
                         sync[comparator_control_pkg::sync_stages-1];
      comparator_irq  <= next_irq_flag & next_ctrl.comparator_irq_enable &
                         global_irq_enable;
      irq                 <= |(next_event_status & next_event_enable);
      positive_pin_read   <= positive_pin_level & ~next_pin_disable[comparator_control_pkg::pos_disable_bit];
      negative_pin_read   <= negative_pin_level & ~next_pin_disable[comparator_control_pkg::neg_disable_bit];
      positive_buffer_off <= next_pin_disable[comparator_control_pkg::pos_disable_bit];
      negative_buffer_off <= next_pin_disable[comparator_control_pkg::neg_disable_bit];
    end
  end

  // Checks
  sequence rise_seen;
    $rose(sync[comparator_control_pkg::sync_stages-1]);
  endsequence

  sequence fall_seen;
    $fell(sync[comparator_control_pkg::sync_stages-1]);
  endsequence

  rising_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl.irq_mode == comparator_control_pkg::mode_rising) ##0 rise_seen |=> irq_flag)
    else $error("rising edge did not set flag");
  reserved_no_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl.irq_mode == comparator_control_pkg::mode_reserved && !irq_flag) |=> !irq_flag)
    else $error("reserved mode set the flag");
  vector_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_vector_ack && !event_hit) |=> !irq_flag)
    else $error("vector did not clear flag");
  sync_latency_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(comparator_raw) ##1 comparator_raw |-> ##1 sync[comparator_control_pkg::sync_stages-1])
    else $error("result latency exceeded");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    comparator_irq |-> $past(global_irq_enable))
    else $error("request without global enable");
  mux_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    converter_enable |=> !analog_select.neg_from_channel)
    else $error("channel used while converter on");
  pin_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_disable[comparator_control_pkg::pos_disable_bit] |-> !positive_pin_read)
    else $error("disabled pin read nonzero");
  capture_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.capture_routing_enable |=> !capture_trigger)
    else $error("capture driven while unrouted");

  falling_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl.irq_mode == comparator_control_pkg::mode_falling) ##0 fall_seen |=> irq_flag)
    else $error("falling edge did not set flag");

  toggle_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl.irq_mode == comparator_control_pkg::mode_toggle) ##0
      $changed(sync[comparator_control_pkg::sync_stages-1]) |=> irq_flag)
    else $error("toggle did not set flag");

  event_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    event_hit |=> irq_flag)
    else $error("event lost against a clear");

  no_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!irq_flag && !event_hit) |=> !irq_flag)
    else $error("flag set without an event");

  one_clears_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == comparator_control_pkg::control_status_addr &&
     pwdata[comparator_control_pkg::irq_flag_bit] && !event_hit) |=> !irq_flag)
    else $error("write of one did not clear flag");

  zero_keeps_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_flag && !irq_vector_ack &&
     !(wr && paddr == comparator_control_pkg::control_status_addr &&
       pwdata[comparator_control_pkg::irq_flag_bit])) |=> irq_flag)
    else $error("flag lost without a clear");

  irq_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
    comparator_irq == (irq_flag && ctrl.comparator_irq_enable && $past(global_irq_enable)))
    else $error("request does not follow flag and enables");

  sync_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(comparator_raw) |-> ##2 !sync[comparator_control_pkg::sync_stages-1])
    else $error("falling result latency exceeded");

  result_source_a: assert property (@(posedge pclk) disable iff (!presetn)
    rise_seen |-> $past(comparator_raw, 2))
    else $error("result rose without raw output");

  flag_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    event_hit |=> event_status[0])
    else $error("flag event not recorded");

  toggle_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(sync[comparator_control_pkg::sync_stages-1]) |=> event_status[1])
    else $error("toggle event not recorded");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(event_status & event_enable))
    else $error("event line does not follow status");

  capture_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
    capture_trigger == $past(ctrl.capture_routing_enable & sync[comparator_control_pkg::sync_stages-1]))
    else $error("capture does not follow result");

  channel_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    analog_select.neg_from_channel == $past(negative_mux_enable & ~converter_enable))
    else $error("negative source select wrong");

  channel_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
    analog_select.neg_channel == $past(channel_select))
    else $error("channel select not passed on");

  bandgap_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    analog_select.use_bandgap == $past(ctrl.bandgap_select))
    else $error("bandgap select not passed on");

  power_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    analog_select.power_down == $past(ctrl.comparator_disable))
    else $error("power down not passed on");

  neg_pin_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_disable[comparator_control_pkg::neg_disable_bit] |-> !negative_pin_read)
    else $error("disabled negative pin read nonzero");

  buffer_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    {negative_buffer_off, positive_buffer_off} == pin_disable)
    else $error("buffer off does not follow disable bits");

  upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && paddr == comparator_control_pkg::pin_disable_addr) |->
      prdata[31:2] == '0)
    else $error("unused disable bits read nonzero");

  status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && paddr == comparator_control_pkg::control_status_addr) |->
      prdata[comparator_control_pkg::result_bit] ==
        $past(sync[comparator_control_pkg::sync_stages-1]))
    else $error("result bit read wrong");

  setup_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("setup cycle not answered");

  idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !psel |=> (!pready && !pslverr))
    else $error("answer without a request");

  unmapped_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !mapped) |=> pslverr)
    else $error("unmapped access not flagged");

  error_pairs_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

endmodule

`default_nettype wire

// ### logic/comparator_control_pkg.sv
// Package: register map, field positions, reset values and carrier types for the comparator control
package comparator_control_pkg;

  localparam logic [11:0] control_status_addr  = 12'h050;
  localparam logic [11:0] converter_ctrl_addr  = 12'h054;
  localparam logic [11:0] pin_disable_addr     = 12'h058;
  localparam logic [11:0] mux_select_addr      = 12'h05c;
  localparam logic [11:0] event_status_addr    = 12'h060;
  localparam logic [11:0] event_clear_addr     = 12'h064;
  localparam logic [11:0] event_enable_addr    = 12'h068;

  localparam int disable_bit          = 7;
  localparam int bandgap_bit          = 6;
  localparam int result_bit           = 5;
  localparam int irq_flag_bit         = 4;
  localparam int irq_enable_bit       = 3;
  localparam int capture_bit          = 2;
  localparam int mode_hi_bit          = 1;
  localparam int mode_lo_bit          = 0;
  localparam int mux_enable_bit       = 6;
  localparam int converter_enable_bit = 7;
  localparam int neg_disable_bit      = 1;
  localparam int pos_disable_bit      = 0;

  localparam logic [7:0] control_status_reset = 8'h00;
  localparam logic [7:0] converter_ctrl_reset = 8'h00;
  localparam logic [1:0] pin_disable_reset    = 2'h0;
  localparam logic [3:0] mux_select_reset     = 4'h0;
  localparam logic [1:0] event_reset          = 2'h0;

  localparam logic [1:0] mode_toggle   = 2'h0;
  localparam logic [1:0] mode_reserved = 2'h1;
  localparam logic [1:0] mode_falling  = 2'h2;
  localparam logic [1:0] mode_rising   = 2'h3;

  // Synchroniser stages in front of the result bit
  localparam int sync_stages = 2;

  typedef struct packed {
    logic       comparator_disable;
    logic       bandgap_select;
    logic       comparator_irq_enable;
    logic       capture_routing_enable;
    logic [1:0] irq_mode;
  } control_t;

  typedef struct packed {
    logic       power_down;
    logic       use_bandgap;
    logic       neg_from_channel;
    logic [2:0] neg_channel;
  } analog_select_t;

endpackage

// ### tb/comparator_control_bench.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none

module comparator_control_bench;
  localparam int bg = 1100;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        raw, gie, ack, ppl, npl, ppr, npr, pbo, nbo, cap, cirq, irq, er;
  comparator_control_pkg::analog_select_t sel;
  int          pos_mv, neg_mv, chan_mv [8], mismatches, compares, m;
  int          mux, conv, ch, bgs;

  comparator_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_raw(raw), .global_irq_enable(gie),
    .irq_vector_ack(ack), .positive_pin_level(ppl), .negative_pin_level(npl),
    .positive_pin_read(ppr), .negative_pin_read(npr), .positive_buffer_off(pbo),
    .negative_buffer_off(nbo), .analog_select(sel), .capture_trigger(cap),
    .comparator_irq(cirq), .irq(irq));

  comparator_core_model #(.bandgap_mv(bg)) core (.analog_select(sel), .pos_mv(pos_mv),
    .neg_mv(neg_mv), .chan_mv(chan_mv), .comparator_raw(raw));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reference decision from the bench's own view of the selection
  function automatic logic exp_res();
    int n;
    n = (mux != 0 && conv == 0) ? chan_mv[ch] : neg_mv;
    return ((bgs != 0) ? bg : pos_mv) > n;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (5) @(posedge pclk);
  endtask

  task automatic results();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    #(25 * 20000);
    mismatches++;
    results();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; gie = 1'b0; ack = 1'b0; ppl = 1'b1; npl = 1'b1; seed = 32'h6412;
    pos_mv = 100; neg_mv = 900; mux = 0; conv = 0; ch = 0; bgs = 0;
    mismatches = 0; compares = 0;
    for (int i = 0; i < 8; i++) chan_mv[i] = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, comparator_control_pkg::control_status_addr, 0);
    chk(rd, 32'h0);
    apb(0, 12'hffc, 0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1, comparator_control_pkg::pin_disable_addr, 32'hff);
    apb(0, comparator_control_pkg::pin_disable_addr, 0);
    chk(rd, 32'h3);
    @(posedge pclk);
    chk({ppr, npr, pbo, nbo}, 4'h3);
    apb(1, comparator_control_pkg::pin_disable_addr, 32'h0);
    @(posedge pclk);
    chk({ppr, npr, pbo, nbo}, 4'hc);
    // Each interrupt mode against one rising and one falling output change
    for (m = 0; m < 4; m++) begin
      apb(1, comparator_control_pkg::control_status_addr, 32'h10 | m);
      pos_mv <= 1000;
      settle();
      apb(0, comparator_control_pkg::control_status_addr, 0);
      chk(rd[5:4], {1'b1, m == 0 || m == 3});
      apb(1, comparator_control_pkg::control_status_addr, 32'h10 | m);
      pos_mv <= 100;
      settle();
      apb(0, comparator_control_pkg::control_status_addr, 0);
      chk(rd[5:4], {1'b0, m == 0 || m == 2});
    end
    // Flag survives a write of zero and goes on a write of one
    apb(1, comparator_control_pkg::control_status_addr, 32'h00);
    pos_mv <= 1000;
    settle();
    apb(1, comparator_control_pkg::control_status_addr, 32'h00);
    apb(0, comparator_control_pkg::control_status_addr, 0);
    chk(rd[4], 1'b1);
    apb(1, comparator_control_pkg::control_status_addr, 32'h10);
    apb(0, comparator_control_pkg::control_status_addr, 0);
    chk(rd[4], 1'b0);
    // Shared mux picks the negative input from every channel
    mux = 1;
    // Converter power reduction is taken as clear outside the block
    apb(1, comparator_control_pkg::converter_ctrl_addr, 32'h40);
    pos_mv <= 500;
    for (int k = 0; k < 8; k++) begin
      ch = k;
      chan_mv[k] <= int'(xs() % 1000);
      apb(1, comparator_control_pkg::mux_select_addr, k);
      settle();
      apb(0, comparator_control_pkg::control_status_addr, 0);
      chk({sel.neg_from_channel, sel.neg_channel}, {1'b1, 3'(k)});
      chk(rd[5], exp_res());
    end
    conv = 1;
    apb(1, comparator_control_pkg::converter_ctrl_addr, 32'hc0);
    settle();
    apb(0, comparator_control_pkg::control_status_addr, 0);
    chk({sel.neg_from_channel, rd[5]}, {1'b0, exp_res()});
    bgs = 1;
    apb(1, comparator_control_pkg::control_status_addr, 32'h44);
    settle();
    apb(0, comparator_control_pkg::control_status_addr, 0);
    chk({sel.use_bandgap, rd[5], cap}, {1'b1, exp_res(), exp_res()});
    apb(1, comparator_control_pkg::control_status_addr, 32'h80);
    repeat (2) @(posedge pclk);
    chk({sel.power_down, cap}, 2'b10);
    // Interrupt request, vector clear, event registers
    bgs = 0; conv = 0; mux = 0;
    apb(1, comparator_control_pkg::converter_ctrl_addr, 32'h0);
    apb(1, comparator_control_pkg::control_status_addr, 32'h10);
    apb(1, comparator_control_pkg::event_clear_addr, 32'h3);
    apb(1, comparator_control_pkg::event_enable_addr, 32'h1);
    apb(1, comparator_control_pkg::control_status_addr, 32'h08);
    gie <= 1'b1;
    pos_mv <= 1000;
    settle();
    chk({cirq, irq}, 2'b11);
    apb(0, comparator_control_pkg::event_status_addr, 0);
    chk(rd, 32'h3);
    gie <= 1'b0;
    settle();
    chk(cirq, 1'b0);
    gie <= 1'b1;
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    settle();
    apb(0, comparator_control_pkg::control_status_addr, 0);
    chk({cirq, rd[4]}, 2'b00);
    apb(1, comparator_control_pkg::event_clear_addr, 32'h3);
    settle();
    chk(irq, 1'b0);
    apb(1, comparator_control_pkg::event_enable_addr, 32'h0);
    pos_mv <= 100;
    settle();
    apb(0, comparator_control_pkg::event_status_addr, 0);
    chk({irq, rd[1:0]}, 3'b011);
    results();
  end
endmodule

`default_nettype wire

// ### tb/comparator_core_model.sv
// Behavioural analog comparator core with its input selection
`timescale 1ns/1ps
`default_nettype none

module comparator_core_model #(
  parameter int bandgap_mv = 1100
) (
  input  wire  comparator_control_pkg::analog_select_t analog_select,
  input  var   int                                     pos_mv,
  input  var   int                                     neg_mv,
  input  var   int                                     chan_mv [8],
  output var   logic                                   comparator_raw
);
  int p;
  int n;

  always_comb begin
    p = analog_select.use_bandgap ? bandgap_mv : pos_mv;
    n = analog_select.neg_from_channel ? chan_mv[analog_select.neg_channel] : neg_mv;
    // Powered down core gives no decision; held low
    comparator_raw = !analog_select.power_down && (p > n);
  end
endmodule

`default_nettype wire
